// ### hw/rcrs_pkg.sv
// Constants for the rate configuration port and result status bytes.
// Assumes a single 100 MHz clock and synchronous resets.
package rcrs_pkg;

  localparam logic [15:0] ADDR_RATE_CFG = 16'h03f7;
  localparam logic [15:0] ADDR_DATA = 16'h03f5;

  localparam logic [1:0] MODE_BASIC = 2'h0;
  localparam logic [1:0] MODE_EXT = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h3;

  localparam int RATE_LSB = 0;
  localparam int RATE_W = 2;
  localparam int PRECOMP_BIT = 2;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_RST = RATE_250K;
  localparam logic PRECOMP_RST = 1'b0;
  localparam logic DENSITY_RST = 1'b1;

  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_POLL = 2'h3;

  localparam int S0_TERM_LSB = 6;
  localparam int S0_SEEK = 5;
  localparam int S0_EQUIP = 4;
  localparam int S0_HEAD = 2;
  localparam int S0_DRV_LSB = 0;
  localparam int S1_END = 7;
  localparam int S1_CRC = 5;
  localparam int S1_LATE = 4;
  localparam int S1_NOSEC = 2;
  localparam int S1_WPROT = 1;
  localparam int S1_MARK = 0;
  localparam int S2_MTYPE = 6;
  localparam int S2_DCRC = 5;
  localparam int S2_CYL = 4;
  localparam int S2_BAD = 1;
  localparam int S2_DMARK = 0;
  localparam logic [7:0] S0_MASK = 8'hf7;
  localparam logic [7:0] S1_MASK = 8'hb7;
  localparam logic [7:0] S2_MASK = 8'h73;

  localparam logic [6:0] RECAL_STEP_LIMIT = 7'h50;
  localparam logic [1:0] INDEX_LIMIT = 2'h2;
  localparam logic [7:0] BAD_TRACK = 8'hff;
  localparam logic [1:0] RESULT_LAST = 2'h2;

  typedef enum logic [2:0] {
    CMD_OTHER, CMD_READ_DATA, CMD_READ_DEL, CMD_WRITE,
    CMD_READ_ID, CMD_READ_TRACK, CMD_RECAL, CMD_REL_SEEK
  } rcrs_cmd_t;

endpackage

// ### hw/rcrs_mem_if.sv
// Port bundle between the status controller and its result byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rcrs_mem_if;
  logic we;
  logic [1:0] waddr;
  logic [7:0] wdata;
  logic re;
  logic [1:0] raddr;
  logic [7:0] rdata;
  modport ctrl(output we, waddr, wdata, re, raddr, input rdata);
  modport store(input we, waddr, wdata, re, raddr, output rdata);
endinterface

// ### hw/rcrs_result_mem.sv
// Four-byte store for captured result status, registered read data.
// Assumes the writer and reader never address the same word at once.
`timescale 1ns/1ps
module rcrs_result_mem (
  input wire logic mclk,
  input wire logic sys_rst,
  rcrs_mem_if.store port
);

  logic [7:0] mem_q [0:3];
  logic [7:0] rdata_q;

  always_ff @(posedge mclk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (port.re) begin
      rdata_q <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rdata_q;

endmodule

// ### hw/rcrs_top.sv
// Rate configuration port and result status byte encoder.
// Assumes host strobes are synchronous one-cycle pulses and the
// command core reports events as one-cycle pulses on mclk.
//
// How it works
// - Port write loads rate bits, reset 10
// - Alternate mode stores inert precomp-disable bit
// - Precomp bit readable only in alternate mode
// - Software reset keeps precomp bit
// - Density output high after hardware reset, then set by each port write
// - Result phase presents status bytes to host
// - Byte zero top bits give termination code
// - Byte zero bit5 marks seek completion
// - Byte zero bit4 flags recal/seek equipment fault
// - Byte zero reports head and drive number
// - Byte one bit7 past last sector
// - Byte one bit5 any CRC error
// - Byte one bit4 overrun or underrun
// - Byte one bit2 sector not found cases
// - Byte one bit1 write protect during writes
// - Byte one bit0 address mark missing
// - Unused status bits read zero
// - Byte two bit6 data mark type mismatch
// - Byte two bit5 payload CRC error
// - Byte two cylinder mismatch, bad track
// - Byte two bit0 data mark missing
// - Hardware reset gives 250K, software keeps
// - Mode field picks register compatibility mode
`timescale 1ns/1ps
module rcrs_top
  import rcrs_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic oc_soft_rst,
  input wire logic rs_soft_rst,
  input wire logic [1:0] iface_mode,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic [1:0] rate_select,
  output logic precomp_disable,
  output logic density_select_out,
  output logic result_phase,
  input wire logic cmd_start,
  input wire rcrs_cmd_t cmd_kind,
  input wire logic exec_done,
  input wire logic [1:0] term_code,
  input wire logic seek_done_in,
  input wire logic head_addr_in,
  input wire logic [1:0] drive_number_in,
  input wire logic step_pulse,
  input wire logic step_out,
  input wire logic track_zero_in,
  input wire logic index_pulse_in,
  input wire logic id_mark_seen,
  input wire logic data_mark_seen,
  input wire logic data_mark_deleted,
  input wire logic data_mark_absent,
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic [7:0] cur_cylinder,
  input wire logic id_crc_err,
  input wire logic data_crc_err,
  input wire logic service_late,
  input wire logic past_last_sector,
  input wire logic terminal_count,
  input wire logic sector_miss,
  input wire logic id_read_fail,
  input wire logic track_seq_fail,
  input wire logic write_protect_in
);

  typedef enum logic [2:0] {
    S_IDLE, S_ST0, S_ST1, S_ST2, S_RES
  } rcrs_state_t;

  function automatic logic rcrs_takes_tc(input rcrs_cmd_t c);
    return c == CMD_READ_DATA || c == CMD_READ_DEL ||
           c == CMD_WRITE;
  endfunction

  function automatic logic [7:0] rcrs_pick(input logic [23:0] v,
                                           input logic [1:0] i);
    logic [7:0] b;
    b = v[7:0];
    case (i)
      2'h1: b = v[15:8];
      2'h2: b = v[23:16];
      default: b = v[7:0];
    endcase
    return b;
  endfunction

  rcrs_mem_if mif();

  rcrs_result_mem u_mem (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .port(mif.store)
  );

  // Either software reset restarts the command side only
  logic core_rst;
  assign core_rst = sys_rst | oc_soft_rst | rs_soft_rst;

  // Host port decode
  logic sel_cfg;
  logic sel_data;
  logic cfg_wr;
  logic alt_mode;
  assign sel_cfg = io_addr == ADDR_RATE_CFG;
  assign sel_data = io_addr == ADDR_DATA;
  assign cfg_wr = io_wr & sel_cfg;
  assign alt_mode = iface_mode == MODE_ALT;

  // Rate configuration
  logic [1:0] rate_q;
  logic [1:0] rate_d;
  logic precomp_q;
  logic precomp_d;
  logic dens_q;
  logic dens_d;
  logic hi_dens;

  // Reserved bits are simply not stored; host must write zero
  assign rate_d = cfg_wr ? io_wdata[RATE_LSB +: RATE_W] : rate_q;
  // Stored but steers nothing in this block
  assign precomp_d = (cfg_wr & alt_mode) ?
                     io_wdata[PRECOMP_BIT] : precomp_q;
  assign hi_dens = rate_d == RATE_500K || rate_d == RATE_1M;
  // Density is active low in the alternate mode
  assign dens_d = cfg_wr ? (hi_dens ^ alt_mode) : dens_q;

  // Only the hardware reset touches these
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rate_q <= RATE_RST;
      precomp_q <= PRECOMP_RST;
      dens_q <= DENSITY_RST;
    end else begin
      rate_q <= rate_d;
      precomp_q <= precomp_d;
      dens_q <= dens_d;
    end
  end

  // Command tracking
  logic active_q;
  rcrs_cmd_t cmd_q;

  always_ff @(posedge mclk) begin
    if (core_rst) begin
      active_q <= 1'b0;
      cmd_q <= CMD_OTHER;
    end else if (cmd_start) begin
      active_q <= 1'b1;
      cmd_q <= cmd_kind;
    end else if (exec_done) begin
      active_q <= 1'b0;
    end
  end

  logic is_rd_data;
  logic is_rd_del;
  logic is_write;
  logic is_recal;
  logic is_rseek;
  logic uses_id;
  assign is_rd_data = active_q && cmd_q == CMD_READ_DATA;
  assign is_rd_del = active_q && cmd_q == CMD_READ_DEL;
  assign is_write = active_q && cmd_q == CMD_WRITE;
  assign is_recal = active_q && cmd_q == CMD_RECAL;
  assign is_rseek = active_q && cmd_q == CMD_REL_SEEK;
  assign uses_id = active_q && cmd_q != CMD_OTHER &&
                   cmd_q != CMD_RECAL && cmd_q != CMD_REL_SEEK;

  // Recalibrate step counter; saturates so a stuck drive stays flagged
  logic [6:0] step_cnt_q;
  logic tz_seen_q;
  logic recal_fail;
  logic rseek_fail;

  always_ff @(posedge mclk) begin
    if (core_rst || cmd_start) begin
      step_cnt_q <= 7'h00;
      tz_seen_q <= 1'b0;
    end else begin
      if (is_recal && step_pulse && !track_zero_in &&
          step_cnt_q != RECAL_STEP_LIMIT) begin
        step_cnt_q <= step_cnt_q + 7'h01;
      end
      if (is_recal && track_zero_in) begin
        tz_seen_q <= 1'b1;
      end
    end
  end

  assign recal_fail = is_recal && step_cnt_q == RECAL_STEP_LIMIT &&
                      !track_zero_in && !tz_seen_q;
  assign rseek_fail = is_rseek & step_pulse & step_out &
                      track_zero_in;

  // Index pulse counting while searching for an identifier mark
  logic idx_prev_q;
  logic [1:0] idx_cnt_q;
  logic id_found_q;
  logic idx_edge;
  logic idx_miss;
  assign idx_edge = index_pulse_in & ~idx_prev_q;

  always_ff @(posedge mclk) begin
    if (core_rst) begin
      idx_prev_q <= 1'b0;
    end else begin
      idx_prev_q <= index_pulse_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (core_rst || cmd_start) begin
      idx_cnt_q <= 2'h0;
      id_found_q <= 1'b0;
    end else begin
      if (uses_id && idx_edge && idx_cnt_q != INDEX_LIMIT) begin
        idx_cnt_q <= idx_cnt_q + 2'h1;
      end
      if (id_mark_seen) begin
        id_found_q <= 1'b1;
      end
    end
  end

  assign idx_miss = uses_id && idx_edge &&
                    idx_cnt_q == INDEX_LIMIT - 2'h1 &&
                    !id_found_q && !id_mark_seen;

  // Per-event decode
  logic cyl_diff;
  logic mtype;
  logic wprot;
  assign cyl_diff = active_q && id_valid &&
                    id_track != cur_cylinder;
  assign mtype = data_mark_seen &&
                 ((is_rd_data && data_mark_deleted) ||
                  (is_rd_del && !data_mark_deleted));
  assign wprot = is_write & write_protect_in;

  logic [7:0] ev1;
  logic [7:0] ev2;
  always_comb begin
    ev1 = 8'h00;
    ev2 = 8'h00;
    ev1[S1_END] = active_q & past_last_sector;
    ev1[S1_CRC] = active_q & (id_crc_err | data_crc_err);
    ev1[S1_LATE] = active_q & service_late;
    ev1[S1_NOSEC] = active_q &
                    (sector_miss | id_read_fail | track_seq_fail);
    ev1[S1_WPROT] = wprot;
    ev1[S1_MARK] = idx_miss | (active_q & data_mark_absent);
    ev2[S2_MTYPE] = mtype;
    ev2[S2_DCRC] = active_q & data_crc_err;
    ev2[S2_CYL] = cyl_diff;
    ev2[S2_BAD] = cyl_diff && id_track == BAD_TRACK;
    ev2[S2_DMARK] = active_q & data_mark_absent;
  end

  // Sticky accumulators: a same-cycle event beats the clear for all but equip_q
  logic [7:0] acc1_q;
  logic [7:0] acc1_d;
  logic [7:0] acc2_q;
  logic [7:0] acc2_d;
  logic tc_q;
  logic tc_d;
  logic seek_q;
  logic seek_d;
  logic equip_q;
  logic equip_d;
  logic equip_ev;

  assign equip_ev = recal_fail | rseek_fail;
  assign acc1_d = (cmd_start ? 8'h00 : acc1_q) | ev1;
  assign acc2_d = (cmd_start ? 8'h00 : acc2_q) | ev2;
  assign tc_d = (cmd_start ? 1'b0 : tc_q) |
                (active_q & terminal_count);
  // Seek results wait for the next status-reporting command
  assign seek_d = (exec_done ? 1'b0 : seek_q) | seek_done_in;
  // Fault level is taken into the captured byte, so here the clear wins
  assign equip_d = exec_done ? 1'b0 : (equip_q | equip_ev);

  always_ff @(posedge mclk) begin
    if (core_rst) begin
      acc1_q <= 8'h00;
      acc2_q <= 8'h00;
      tc_q <= 1'b0;
      seek_q <= 1'b0;
      equip_q <= 1'b0;
    end else begin
      acc1_q <= acc1_d;
      acc2_q <= acc2_d;
      tc_q <= tc_d;
      seek_q <= seek_d;
      equip_q <= equip_d;
    end
  end

  // Status bytes as seen at the end of execution
  logic end_no_tc;
  logic [7:0] st0_new;
  logic [7:0] st1_new;
  logic [7:0] st2_new;
  assign end_no_tc = rcrs_takes_tc(cmd_q) & ~tc_d;

  always_comb begin
    st0_new = 8'h00;
    st0_new[S0_TERM_LSB +: 2] = term_code;
    st0_new[S0_SEEK] = seek_q | seek_done_in;
    st0_new[S0_EQUIP] = equip_q | equip_ev;
    st0_new[S0_HEAD] = head_addr_in;
    st0_new[S0_DRV_LSB +: 2] = drive_number_in;
    st0_new = st0_new & S0_MASK;
    st1_new = acc1_d;
    st1_new[S1_END] = acc1_d[S1_END] | end_no_tc;
    st1_new = st1_new & S1_MASK;
    st2_new = acc2_d & S2_MASK;
  end

  // Result sequencing
  rcrs_state_t state_q;
  rcrs_state_t state_d;
  logic [23:0] snap_q;
  logic [1:0] rd_idx_q;
  logic [1:0] st_idx;
  logic storing;
  logic res_rd;
  logic res_last;

  assign res_rd = io_rd & sel_data & (state_q == S_RES);
  assign res_last = rd_idx_q == RESULT_LAST;
  assign storing = state_q == S_ST0 || state_q == S_ST1 ||
                   state_q == S_ST2;
  assign st_idx = state_q == S_ST1 ? 2'h1 :
                  state_q == S_ST2 ? 2'h2 : 2'h0;

  always_comb begin
    state_d = state_q;
    if (exec_done) begin
      state_d = S_ST0;
    end else begin
      case (state_q)
        S_IDLE: state_d = S_IDLE;
        S_ST0: state_d = S_ST1;
        S_ST1: state_d = S_ST2;
        S_ST2: state_d = S_RES;
        S_RES: begin
          if (res_rd && res_last) begin
            state_d = S_IDLE;
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
  end

  // Snapshot is frozen until the next command ends
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      state_q <= S_IDLE;
      snap_q <= 24'h000000;
      rd_idx_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (exec_done) begin
        snap_q <= {st2_new, st1_new, st0_new};
        rd_idx_q <= 2'h0;
      end else if (res_rd) begin
        rd_idx_q <= rd_idx_q + 2'h1;
      end
    end
  end

  assign mif.we = storing;
  assign mif.waddr = st_idx;
  assign mif.wdata = rcrs_pick(snap_q, st_idx);
  assign mif.re = res_rd;
  assign mif.raddr = rd_idx_q;

  // Read path: fixed two-cycle answer for every read strobe
  logic [7:0] imm_data;
  logic [7:0] imm_q;
  logic rd_pend_q;
  logic rd_mem_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic res_q;

  // Precomp bit is visible only in the alternate mode
  assign imm_data = (sel_cfg && alt_mode) ?
                    {5'h00, precomp_q, rate_q} : 8'h00;

  always_ff @(posedge mclk) begin
    if (core_rst) begin
      rd_pend_q <= 1'b0;
      rd_mem_q <= 1'b0;
      imm_q <= 8'h00;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      res_q <= 1'b0;
    end else begin
      rd_pend_q <= io_rd;
      rd_mem_q <= res_rd;
      imm_q <= imm_data;
      rvalid_q <= rd_pend_q;
      res_q <= state_d == S_RES;
      if (rd_pend_q) begin
        rdata_q <= rd_mem_q ? mif.rdata : imm_q;
      end
    end
  end

  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;
  assign result_phase = res_q;
  assign rate_select = rate_q;
  assign precomp_disable = precomp_q;
  assign density_select_out = dens_q;

endmodule

// ### bench/rcrs_host.sv
// Host processor model: drives the I/O strobes and collects read answers.
// Assumes one-cycle strobes sampled on the rising edge of mclk.
`timescale 1ns/1ps
module rcrs_host (
  input wire logic mclk,
  input wire logic [1:0] iface_mode,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // Reserved bits always go out as zero
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d & ((iface_mode == 2'h3) ? 8'h07 : 8'h03);
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    io_wdata <= ~io_wdata;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d,
      output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge mclk);
      #1;
      if (io_rvalid === 1'b1) begin
        ok = 1'b1;
        d = io_rdata;
      end
    end
  endtask
endmodule

// ### bench/rcrs_props.sv
// Checker for the rate port and result read timing of rcrs_top.
// Assumes it is bound to rcrs_top and sees only its ports.
`timescale 1ns/1ps
module rcrs_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic oc_soft_rst,
  input wire logic rs_soft_rst,
  input wire logic [1:0] iface_mode,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic [1:0] rate_select,
  input wire logic precomp_disable,
  input wire logic density_select_out,
  input wire logic result_phase,
  input wire logic exec_done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire cfg_wr = io_wr && io_addr == 16'h03f7;
  wire any_rst = sys_rst || oc_soft_rst || rs_soft_rst;

  a_hw_reset_vals: assert property (
    $fell(sys_rst) |-> rate_select == 2'h2 && !precomp_disable
      && density_select_out) else $error("reset values wrong");
  a_rate_load: assert property (
    cfg_wr |=> rate_select == $past(io_wdata[1:0]))
    else $error("rate field not loaded");
  a_precomp_alt: assert property (
    cfg_wr && iface_mode == 2'h3 |=> precomp_disable == $past(io_wdata[2]))
    else $error("precomp bit not stored");
  a_precomp_kept: assert property (
    cfg_wr && iface_mode != 2'h3 |=> $stable(precomp_disable))
    else $error("precomp bit changed outside alternate mode");
  a_soft_keeps: assert property (
    (oc_soft_rst || rs_soft_rst) && !io_wr
      |=> $stable({rate_select, precomp_disable, density_select_out}))
    else $error("soft reset disturbed config");
  a_read_answer: assert property (
    disable iff (any_rst) io_rd |-> ##2 io_rvalid)
    else $error("read answer late");
  a_cfg_read_mode: assert property (
    disable iff (any_rst) io_rd && io_addr == 16'h03f7 |-> ##2 io_rdata ==
      ($past(iface_mode, 2) == 2'h3 ? {5'h00, $past(precomp_disable, 2),
      $past(rate_select, 2)} : 8'h00))
    else $error("config read data wrong");
  a_result_rise: assert property (
    disable iff (any_rst) exec_done |-> ##4 result_phase)
    else $error("result phase not entered");
  a_idle_data: assert property (
    disable iff (any_rst)
    io_rd && io_addr == 16'h03f5 && !result_phase |-> ##2 io_rdata == 8'h00)
    else $error("data port not zero outside result phase");
endmodule

bind rcrs_top rcrs_props u_props (.mclk, .sys_rst, .oc_soft_rst,
  .rs_soft_rst, .iface_mode, .io_addr, .io_wr, .io_rd, .io_wdata,
  .io_rdata, .io_rvalid, .rate_select, .precomp_disable,
  .density_select_out, .result_phase, .exec_done);

// ### bench/rcrs_tb_top.sv
// Self-checking bench for rcrs_top: config port and result status bytes.
// Assumes the host model answers reads and events are one-cycle pulses.
`timescale 1ns/1ps
module rcrs_tb_top;
  import rcrs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic oc_soft_rst = 1'b0;
  logic rs_soft_rst = 1'b0;
  logic [1:0] iface_mode = 2'h0;
  logic [15:0] io_addr;
  logic io_wr, io_rd, io_rvalid;
  logic [7:0] io_wdata, io_rdata;
  logic [1:0] rate_select;
  logic precomp_disable, density_select_out, result_phase;
  logic cmd_start = 1'b0;
  logic exec_done = 1'b0;
  rcrs_cmd_t cmd_kind = CMD_OTHER;
  logic [1:0] term_code = 2'h0;
  logic [1:0] drive_number_in = 2'h0;
  logic head_addr_in = 1'b0, step_pulse = 1'b0, step_out = 1'b0;
  logic track_zero_in = 1'b0, index_pulse_in = 1'b0;
  logic data_mark_deleted = 1'b0, write_protect_in = 1'b0;
  logic [7:0] id_track = 8'h05;
  logic [7:0] cur_cylinder = 8'h05;
  // Event pulses packed so one scenario argument sets them all
  logic [12:0] ev = 13'h0000;
  int fail_count = 0;
  int comparisons = 0;

  always #5 mclk = ~mclk;

  rcrs_top dut (.mclk, .sys_rst, .oc_soft_rst, .rs_soft_rst, .iface_mode,
    .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rvalid,
    .rate_select, .precomp_disable, .density_select_out, .result_phase,
    .cmd_start, .cmd_kind, .exec_done, .term_code, .seek_done_in(ev[12]),
    .head_addr_in, .drive_number_in, .step_pulse, .step_out,
    .track_zero_in, .index_pulse_in, .id_mark_seen(ev[0]),
    .data_mark_seen(ev[1]), .data_mark_deleted, .data_mark_absent(ev[2]),
    .id_valid(ev[3]), .id_track, .cur_cylinder,
    .id_crc_err(ev[4]), .data_crc_err(ev[5]), .service_late(ev[6]),
    .past_last_sector(ev[7]), .terminal_count(ev[8]),
    .sector_miss(ev[9]), .id_read_fail(ev[10]), .track_seq_fail(ev[11]),
    .write_protect_in);

  rcrs_host host (.mclk, .iface_mode, .io_rdata, .io_rvalid, .io_addr,
    .io_wr, .io_rd, .io_wdata);

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      fail_count++;
      wrap_up();
    end else
      chk(d, exp);
  endtask

  task automatic t_cfg();
    chk({6'h00, rate_select}, 8'h02);
    chk({7'h00, density_select_out}, 8'h01);
    @(posedge mclk);
    iface_mode <= 2'h3;
    rd_chk(16'h03f7, 8'h02);
    for (int r = 0; r < 4; r++) begin
      host.wr(16'h03f7, 8'hfc | r[7:0]);
      rd_chk(16'h03f7, 8'h04 | r[7:0]);
      chk({7'h00, density_select_out}, {7'h00, r == 1 || r == 2});
    end
    @(posedge mclk);
    iface_mode <= 2'h0;
    host.wr(16'h03f7, 8'h01);
    rd_chk(16'h03f7, 8'h00);
    @(posedge mclk);
    oc_soft_rst <= 1'b1;
    @(posedge mclk);
    oc_soft_rst <= 1'b0;
    rs_soft_rst <= 1'b1;
    @(posedge mclk);
    rs_soft_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({5'h00, precomp_disable, rate_select}, 8'h05);
    chk({7'h00, density_select_out}, 8'h00);
    $display("test cfg done");
  endtask

  // Level inputs lv: deleted, step_out, track zero, protect, head, drive
  task automatic t_cmd(input rcrs_cmd_t k, input logic [1:0] tc,
      input logic [6:0] lv, input logic [7:0] trk, input logic [12:0] e,
      input int steps, input int idx, input logic [23:0] exp);
    int n;
    @(posedge mclk);
    {data_mark_deleted, step_out, track_zero_in, write_protect_in,
      head_addr_in, drive_number_in} <= lv;
    id_track <= trk;
    cmd_kind <= k;
    term_code <= tc;
    cmd_start <= 1'b1;
    @(posedge mclk);
    cmd_start <= 1'b0;
    ev <= e;
    @(posedge mclk);
    ev <= 13'h0000;
    repeat (steps) begin
      step_pulse <= 1'b1;
      @(posedge mclk);
      step_pulse <= 1'b0;
      @(posedge mclk);
    end
    repeat (idx) begin
      index_pulse_in <= 1'b1;
      @(posedge mclk);
      index_pulse_in <= 1'b0;
      @(posedge mclk);
    end
    exec_done <= 1'b1;
    @(posedge mclk);
    exec_done <= 1'b0;
    // Sample off the edge so the registered flag has settled
    for (n = 0; n < 10 && result_phase !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    chk({7'h00, result_phase}, 8'h01);
    if (result_phase !== 1'b1)
      wrap_up();
    for (n = 2; n >= 0; n--)
      rd_chk(16'h03f5, exp[n*8 +: 8]);
    rd_chk(16'h03f5, 8'h00);
    $display("test %s done", k.name());
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_cfg();
    t_cmd(CMD_READ_DEL, TERM_ABNORMAL, 7'h06, 8'hff,
      13'h025e, 0, 0, 24'h46b553);
    t_cmd(CMD_WRITE, TERM_NORMAL, 7'h09, 8'h05, 13'h0520, 0, 2,
      24'h012720);
    t_cmd(CMD_RECAL, TERM_POLL, 7'h00, 8'h05, 13'h1000, 80, 0,
      24'hf00000);
    t_cmd(CMD_OTHER, TERM_NORMAL, 7'h00, 8'h05, 13'h0000, 0, 0,
      24'h000000);
    t_cmd(CMD_REL_SEEK, TERM_INVALID, 7'h37, 8'h05, 13'h0000, 1, 0,
      24'h970000);
    t_cmd(CMD_READ_TRACK, TERM_NORMAL, 7'h00, 8'h05, 13'h0889, 0, 2,
      24'h008400);
    t_cmd(CMD_READ_DATA, TERM_ABNORMAL, 7'h40, 8'h07, 13'h010a, 0, 0,
      24'h400050);
    wrap_up();
  end
endmodule
